// *** rtl/lcd_seg_driver.sv ***
/*
 * Multiplexed LCD segment driver: SFR register file, RTC clock divider,
 * refresh divider, backplane sequencer and 32 segment pin encoders.
 * Levels are in sixths of the panel supply: 0 and 6 are the rails,
 * 3 is the half-bias midpoint, 2 and 4 the third-bias steps.
 * Each backplane phase is driven twice, normal then inverted, so the
 * glass sees no net DC over a frame.
 * Segment data reaches the pins through a shadow copy taken at each
 * frame end, so a pattern update never tears a frame; while the panel
 * is disabled the shadow simply follows the data registers.
 * Clearing the enable grounds every backplane and segment output on the next edge.
 * Assumes an 8-bit SFR write/read port on ref_clk and an RTC tick
 * input from another clock domain, synchronised here; the RTC period
 * must span several ref_clk cycles for its edges to be seen.
 */
`timescale 1ns/10ps
`include "lcd_seg_defines.svh"
module lcd_seg_driver (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // SFR port
    input  wire logic [7:0]          sfr_addr,
    input  wire logic                sfr_wr,
    input  wire logic                sfr_rd,
    input  wire logic [7:0]          sfr_wdata,
    output logic [7:0]               sfr_rdata_ff,
    // RTC oscillator output
    input  wire logic                rtc_clk_in,
    // Panel drive, levels in sixths of panel supply
    output logic [4*3-1:0]           backplane_level_ff,
    output logic [`SEG_PINS*3-1:0]   segment_level_ff,
    output logic                     size_wide_ff,
    output logic                     panel_active_ff,
    output logic                     frame_start_ff
);
    import lcd_seg_pkg::*;

    // Software-visible registers and the frame shadow
    logic [7:0]   segment_data_ff [`SEG_REGS];
    logic [7:0]   shadow_ff [`SEG_REGS];
    logic [7:0]   panel_control_ff;
    logic [7:0]   panel_misc_ff;
    logic [15:0]  refresh_div_ff;

    // Timing chain
    logic [2:0]   rtc_sync_ff;
    logic         rtc_rise;
    logic [1:0]   panel_clock_divider_cnt_ff;
    logic [15:0]  refresh_cnt_ff;
    logic [1:0]   phase_ff;
    logic         invert_ff;
    logic         lcd_tick;
    logic         step;
    logic         frame_end;
    logic         shadow_load;
    logic [1:0]   last_phase;

    // Register port decode
    logic [4:0]   wr_idx;
    logic [4:0]   rd_idx;
    logic         wr_ctl;
    logic         wr_misc;
    logic         wr_div_lo;
    logic         wr_div_hi;
    logic [7:0]   nxt_rdata;

    // Next values of the output levels
    logic [`SEG_PINS*3-1:0] nxt_seg_level;
    logic [4*3-1:0]         nxt_bp_level;

    // Decoded control fields
    mux_mode_t    mux_mode;
    logic         enabled;
    logic         half_bias;
    logic         blank_all;

    // Decoded control fields
    assign mux_mode  = mux_mode_t'(panel_control_ff[`CTL_MUX_LSB +: 2]);
    assign enabled   = panel_misc_ff[`MISC_ENABLE_BIT];
    assign half_bias = panel_control_ff[`CTL_BIAS_BIT];
    assign blank_all = panel_control_ff[`CTL_BLANK_BIT];

    // Address decode to data register index, 5'h1f when not a data reg
    function automatic logic [4:0] data_index(input logic [7:0] a);
        case (a)
            `SEG_DATA_0_ADDR:  data_index = 5'h00;
            `SEG_DATA_1_ADDR:  data_index = 5'h01;
            `SEG_DATA_2_ADDR:  data_index = 5'h02;
            `SEG_DATA_3_ADDR:  data_index = 5'h03;
            `SEG_DATA_4_ADDR:  data_index = 5'h04;
            `SEG_DATA_5_ADDR:  data_index = 5'h05;
            `SEG_DATA_6_ADDR:  data_index = 5'h06;
            `SEG_DATA_7_ADDR:  data_index = 5'h07;
            `SEG_DATA_8_ADDR:  data_index = 5'h08;
            `SEG_DATA_9_ADDR:  data_index = 5'h09;
            `SEG_DATA_10_ADDR: data_index = 5'h0a;
            `SEG_DATA_11_ADDR: data_index = 5'h0b;
            `SEG_DATA_12_ADDR: data_index = 5'h0c;
            `SEG_DATA_13_ADDR: data_index = 5'h0d;
            `SEG_DATA_14_ADDR: data_index = 5'h0e;
            `SEG_DATA_15_ADDR: data_index = 5'h0f;
            default:           data_index = 5'h1f;
        endcase
    endfunction

    // One decoder serves both directions
    assign wr_idx = data_index(sfr_addr);
    assign rd_idx = data_index(sfr_addr);

    // Write strobes for the control registers
    assign wr_ctl    = sfr_wr && (sfr_addr == `PANEL_CONTROL_ADDR);
    assign wr_misc   = sfr_wr && (sfr_addr == `PANEL_MISC_ADDR);
    assign wr_div_lo = sfr_wr && (sfr_addr == `REFRESH_DIV_LOW_ADDR);
    assign wr_div_hi = sfr_wr && (sfr_addr == `REFRESH_DIV_HIGH_ADDR);

    // Segment data registers written by software
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `SEG_REGS; i++) begin
                segment_data_ff[i] <= `REG_RESET;
            end
        end else if (sfr_wr && !wr_idx[4]) begin
            segment_data_ff[wr_idx[3:0]] <= sfr_wdata;
        end
    end

    // Control register, reserved bit 7 kept at zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            panel_control_ff <= `REG_RESET;
        end else if (wr_ctl) begin
            panel_control_ff <= sfr_wdata & `CTL_WRITE_MASK;
        end
    end

    // Misc control register, bit 0 enables driving
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            panel_misc_ff <= `REG_RESET;
        end else if (wr_misc) begin
            panel_misc_ff <= sfr_wdata;
        end
    end

    // Refresh divider high and low bytes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_div_ff <= `REFRESH_DIV_RESET;
        end else if (wr_div_lo) begin
            refresh_div_ff[7:0] <= sfr_wdata;
        end else if (wr_div_hi) begin
            refresh_div_ff[15:8] <= sfr_wdata;
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (!rd_idx[4]) begin
            nxt_rdata = segment_data_ff[rd_idx[3:0]];
        end else begin
            case (sfr_addr)
                `PANEL_CONTROL_ADDR:    nxt_rdata = panel_control_ff;
                `PANEL_MISC_ADDR:       nxt_rdata = panel_misc_ff;
                `REFRESH_DIV_LOW_ADDR:  nxt_rdata = refresh_div_ff[7:0];
                `REFRESH_DIV_HIGH_ADDR: nxt_rdata = refresh_div_ff[15:8];
                default:                nxt_rdata = 8'h00;
            endcase
        end
    end

    // Read data register, updated on a read strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_ff <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata_ff <= nxt_rdata;
        end
    end

    // RTC input synchroniser and rising edge detect on stages two/three
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rtc_sync_ff <= 3'h0;
        end else begin
            rtc_sync_ff <= {rtc_sync_ff[1:0], rtc_clk_in};
        end
    end

    // Rising RTC edge, read from the synchronised stages only
    assign rtc_rise = rtc_sync_ff[1] & ~rtc_sync_ff[2];

    // Divide RTC edges by 1, 2 or 4; reserved code acts as 4
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            panel_clock_divider_cnt_ff <= 2'h0;
        end else if (rtc_rise) begin
            panel_clock_divider_cnt_ff <= panel_clock_divider_cnt_ff + 2'h1;
        end
    end

    // LCD tick: one RTC edge in 1, 2 or 4
    always_comb begin
        lcd_tick = rtc_rise;
        case (panel_control_ff[`CTL_PANEL_CLOCK_DIVIDER_LSB +: 2])
            2'h0:    lcd_tick = lcd_tick;
            2'h1:    lcd_tick = lcd_tick & panel_clock_divider_cnt_ff[0];
            default: lcd_tick = lcd_tick & (&panel_clock_divider_cnt_ff);
        endcase
    end

    // Refresh divider sets ticks per backplane phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_cnt_ff <= 16'h0000;
        end else if (!enabled) begin
            refresh_cnt_ff <= 16'h0000;
        end else if (lcd_tick) begin
            refresh_cnt_ff <= step ? 16'h0000 : refresh_cnt_ff + 16'h0001;
        end
    end

    // Last tick of a half-phase
    assign step = lcd_tick && (refresh_cnt_ff >= refresh_div_ff);

    // Highest backplane phase for the mux mode
    always_comb begin
        case (mux_mode)
            MUX_STATIC: last_phase = 2'h0;
            MUX_TWO:    last_phase = 2'h1;
            MUX_THREE:  last_phase = 2'h2;
            MUX_FOUR:   last_phase = 2'h3;
            default:    last_phase = 2'h0;
        endcase
    end

    // Frame ends after the inverted half of the last phase
    assign frame_end = step && invert_ff && (phase_ff >= last_phase);

    // Shadow follows the data while idle, else only at frame end
    assign shadow_load = frame_end || !enabled;

    // Phase sequencer: each phase drives normal then inverted half
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff  <= 2'h0;
            invert_ff <= 1'b0;
        end else if (!enabled) begin
            phase_ff  <= 2'h0;
            invert_ff <= 1'b0;
        end else if (step) begin
            invert_ff <= ~invert_ff;
            if (invert_ff) begin
                phase_ff <= frame_end ? 2'h0 : phase_ff + 2'h1;
            end
        end
    end

    // Shadow copy of data loaded at frame boundaries and while disabled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `SEG_REGS; i++) begin
                shadow_ff[i] <= `REG_RESET;
            end
        end else if (shadow_load) begin
            shadow_ff <= segment_data_ff;
        end
    end

    // Frame start pulse, one cycle after each frame end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_start_ff <= 1'b0;
        end else begin
            frame_start_ff <= frame_end;
        end
    end

    // Enable flag as seen on the pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            panel_active_ff <= 1'b0;
        end else begin
            panel_active_ff <= enabled;
        end
    end

    // Copy of the panel size select
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            size_wide_ff <= 1'b0;
        end else begin
            size_wide_ff <= panel_control_ff[`CTL_SIZE_BIT];
        end
    end

    // One encoder per segment pin, pin n from register n/2
    for (genvar p = 0; p < `SEG_PINS; p++) begin : g_pin
        lcd_seg_wave u_wave (
            .nibble    (shadow_ff[p/2][(p%2)*4 +: 4]),
            .phase     (phase_ff),
            .invert    (invert_ff),
            .mux_mode  (mux_mode),
            .half_bias (half_bias),
            .blank     (blank_all),
            .level     (nxt_seg_level[p*3 +: 3])
        );
    end

    // Backplane levels: selected plane (every plane in static) at an extreme, others at 3 in half bias, 2 or 4 in third bias
    always_comb begin
        for (int b = 0; b < `BACKPLANES; b++) begin
            if (b[1:0] == phase_ff || mux_mode == MUX_STATIC) begin
                nxt_bp_level[b*3 +: 3] = invert_ff ? 3'h0 : 3'h6;
            end else if (half_bias) begin
                nxt_bp_level[b*3 +: 3] = 3'h3;
            end else begin
                nxt_bp_level[b*3 +: 3] = invert_ff ? 3'h4 : 3'h2;
            end
        end
    end

    // Segment pin levels, grounded while disabled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            segment_level_ff <= '0;
        end else if (!enabled) begin
            segment_level_ff <= '0;
        end else begin
            segment_level_ff <= nxt_seg_level;
        end
    end

    // Backplane levels, grounded while disabled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            backplane_level_ff <= '0;
        end else if (!enabled) begin
            backplane_level_ff <= '0;
        end else begin
            backplane_level_ff <= nxt_bp_level;
        end
    end
endmodule // lcd_seg_driver

// *** rtl/lcd_seg_defines.svh ***
/*
 * Constants for the multiplexed LCD segment driver: register offsets,
 * field positions, reset values and timing counts.
 * Assumes an 8-bit special function register port and a 200 MHz ref_clk.
 */
// Functional notes
// - Drive static, 2-, 3- and 4-mux panels with half or third bias.
// - All panel timing comes from the RTC oscillator, optionally divided.
// - Waveforms are built internally from segment data registers only.
// - Misc control bit 0 starts driving; software sets it last.
// - Sixteen byte registers hold thirty-two nibbles, one per segment pin.
// - Nibble bit n controls the segment on backplane n.
// - Static mode uses only nibble bit 0.
// - 2-, 3-, 4-mux use the low two, three, four bits.
// - A one drives the segment on, a zero drives it off.
// - Clock divider codes 00, 01, 10 divide by 1, 2, 4; 11 reserved.
// - Multiplex select 00..11 chooses static, 2-, 3-, 4-mux.
// - Bias bit clear is third bias, set is half; ignored in static.
// - Blank bit set turns every segment off regardless of data.
`ifndef LCD_SEG_DEFINES_SVH
`define LCD_SEG_DEFINES_SVH

// Register offsets
`define SEG_DATA_0_ADDR       8'h89
`define SEG_DATA_1_ADDR       8'h8a
`define SEG_DATA_2_ADDR       8'h8b
`define SEG_DATA_3_ADDR       8'h8c
`define SEG_DATA_4_ADDR       8'h8d
`define SEG_DATA_5_ADDR       8'h8e
`define SEG_DATA_6_ADDR       8'h91
`define SEG_DATA_7_ADDR       8'h92
`define SEG_DATA_8_ADDR       8'h93
`define SEG_DATA_9_ADDR       8'h94
`define SEG_DATA_10_ADDR      8'h95
`define SEG_DATA_11_ADDR      8'h96
`define SEG_DATA_12_ADDR      8'h97
`define SEG_DATA_13_ADDR      8'h99
`define SEG_DATA_14_ADDR      8'h9a
`define SEG_DATA_15_ADDR      8'h9b
`define PANEL_CONTROL_ADDR    8'h9d
`define PANEL_MISC_ADDR       8'h9e
`define REFRESH_DIV_LOW_ADDR  8'h9f
`define REFRESH_DIV_HIGH_ADDR 8'ha0

// Panel control fields
`define CTL_PANEL_CLOCK_DIVIDER_LSB   5
`define CTL_BLANK_BIT    4
`define CTL_SIZE_BIT     3
`define CTL_MUX_LSB      1
`define CTL_BIAS_BIT     0
`define CTL_WRITE_MASK   8'h7f
`define MISC_ENABLE_BIT  0
`define REG_RESET        8'h00

// Number of data registers and segment pins
`define SEG_REGS         16
`define SEG_PINS         32
`define BACKPLANES       4

// Refresh divider reset value
`define REFRESH_DIV_RESET 16'h0010

`endif

// *** rtl/lcd_seg_pkg.sv ***
/*
 * Types for the multiplexed LCD segment driver.
 * Assumes lcd_seg_defines.svh supplies the numeric constants.
 */
package lcd_seg_pkg;
    // Multiplex select codes
    typedef enum logic [1:0] {
        MUX_STATIC = 2'h0,
        MUX_TWO    = 2'h1,
        MUX_THREE  = 2'h2,
        MUX_FOUR   = 2'h3
    } mux_mode_t;

    // Drive level on a pin: fraction of the panel supply, in sixths
    typedef logic [2:0] drive_level_t;
endpackage

// *** rtl/lcd_seg_wave.sv ***
/*
 * Waveform encoder for one segment pin: turns a nibble, the current
 * backplane phase and the mode into a drive level in sixths of supply.
 * Assumes phase and mode come from flip-flops on the same clock.
 */
`timescale 1ns/10ps
`include "lcd_seg_defines.svh"
module lcd_seg_wave (
    // Segment data and timing
    input  wire logic [3:0]                nibble,
    input  wire logic [1:0]                phase,
    input  wire logic                      invert,
    // Mode
    input  wire lcd_seg_pkg::mux_mode_t    mux_mode,
    input  wire logic                      half_bias,
    input  wire logic                      blank,
    // Level out
    output logic [2:0]                     level
);
    import lcd_seg_pkg::*;

    logic seg_on;

    // Pick the bit for the active backplane, blank forces off
    always_comb begin
        seg_on = nibble[phase] & ~blank;
        if (mux_mode == MUX_STATIC) begin
            seg_on = nibble[0] & ~blank;
        end
    end

    // Levels in sixths: 0,2,3,4,6 cover 1/3 and 1/2 bias
    always_comb begin
        if (mux_mode == MUX_STATIC) begin
            level = (seg_on ^ invert) ? 3'h0 : 3'h6;
        end else if (half_bias) begin
            level = seg_on ? (invert ? 3'h6 : 3'h0) : 3'h3;
        end else if (seg_on) begin
            level = invert ? 3'h6 : 3'h0;
        end else begin
            level = invert ? 3'h2 : 3'h4;
        end
    end
endmodule // lcd_seg_wave

// *** dv/lcd_seg_checker.sv ***
/* Port checker for the LCD segment driver.
   Assumes it is bound to lcd_seg_driver, all on ref_clk. */
`timescale 1ns/10ps
`include "lcd_seg_defines.svh"
module lcd_seg_checker (
    // Clock and reset
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    // Register port
    input wire logic [7:0]             sfr_addr,
    input wire logic                   sfr_wr,
    input wire logic                   sfr_rd,
    input wire logic [7:0]             sfr_wdata,
    input wire logic [7:0]             sfr_rdata_ff,
    // Panel drive
    input wire logic [4*3-1:0]         backplane_level_ff,
    input wire logic [`SEG_PINS*3-1:0] segment_level_ff,
    input wire logic                   panel_active_ff,
    input wire logic                   frame_start_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Write, gap, read of one address
    sequence wr_at(logic [7:0] a);
        sfr_wr && sfr_addr == a;
    endsequence
    sequence rd_at(logic [7:0] a);
        !sfr_wr && sfr_rd && sfr_addr == a;
    endsequence
    property readback(logic [7:0] a, logic [7:0] m);
        wr_at(a) ##1 !sfr_wr ##1 rd_at(a)
            |=> sfr_rdata_ff == ($past(sfr_wdata, 3) & m);
    endproperty
    // Register and panel relations
    ctl_readback_a: assert property (
        readback(`PANEL_CONTROL_ADDR, `CTL_WRITE_MASK))
        else $error("control readback wrong");
    misc_readback_a: assert property (
        readback(`PANEL_MISC_ADDR, 8'hff)) else $error("misc readback wrong");
    data_readback_a: assert property (
        readback(`SEG_DATA_0_ADDR, 8'hff)) else $error("data readback wrong");
    unmapped_read_a: assert property (
        sfr_rd && sfr_addr == 8'h90 |=> sfr_rdata_ff == 8'h00)
        else $error("unmapped read not zero");
    read_holds_a: assert property (
        !sfr_rd |=> $stable(sfr_rdata_ff)) else $error("read data moved");
    enable_follows_a: assert property (
        wr_at(`PANEL_MISC_ADDR) |-> ##2
            panel_active_ff == $past(sfr_wdata[0], 2))
        else $error("enable not taken");
    disabled_idle_a: assert property (
        !panel_active_ff [*2] |-> backplane_level_ff == '0
            && segment_level_ff == '0) else $error("drive while disabled");
    level_range_a: assert property (
        backplane_level_ff[2:0] <= 3'h6 && backplane_level_ff[5:3] <= 3'h6
        && backplane_level_ff[8:6] <= 3'h6 && backplane_level_ff[11:9] <= 3'h6)
        else $error("plane level out of range");
    frame_pulse_a: assert property (
        frame_start_ff |=> !frame_start_ff) else $error("frame pulse too long");
endmodule // lcd_seg_checker

bind lcd_seg_driver lcd_seg_checker u_chk (.ref_clk, .rst_n, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_ff, .backplane_level_ff,
    .segment_level_ff, .panel_active_ff, .frame_start_ff);

// *** dv/lcd_glass.sv ***
/* Passive glass model: a segment is lit when its pin and a selected
   backplane stand at opposite rails. Assumes levels in sixths. */
`timescale 1ns/10ps
module lcd_glass (
    // Clock
    input wire logic          ref_clk,
    // Drive levels
    input wire logic [11:0]   bp_level,
    input wire logic [95:0]   seg_level,
    // Seen state, bit 4p+b is pin p on plane b
    output logic     [127:0]  lit_ff
);
    // Latch each segment while its plane sits at a rail
    always_ff @(posedge ref_clk) begin
        for (int b = 0; b < 4; b++) begin
            for (int p = 0; p < 32; p++) begin
                if (bp_level[3*b+:3] inside {3'h0, 3'h6})
                    lit_ff[4*p+b] <= (bp_level[3*b+:3] ^ seg_level[3*p+:3])
                        == 3'h6;
            end
        end
    end
endmodule // lcd_glass

// *** dv/tb.sv ***
/* Self-checking bench for the LCD segment driver with a glass model.
   Assumes a 200 MHz ref_clk and an RTC wave of eight clocks. */
`timescale 1ns/10ps
`include "lcd_seg_defines.svh"
module tb;
    import lcd_seg_pkg::*;
    typedef struct {
        logic [127:0] exp;
        logic [127:0] msk;
        int           at;
        int           per;
    } glass_t;
    logic         ref_clk, rst_n, sfr_wr, sfr_rd, rtc_clk_in, rd_seen;
    logic         size_wide_ff, panel_active_ff, frame_start_ff;
    logic [7:0]   sfr_addr, sfr_wdata, sfr_rdata_ff, d [16];
    logic [11:0]  backplane_level_ff;
    logic [95:0]  segment_level_ff;
    logic [127:0] lit_ff;
    logic [7:0]   rd_q [$];
    glass_t       g_q [$];
    int           fail_count, check_count, cyc, fcnt, last_fs;

    lcd_seg_driver u_dut (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata_ff, .rtc_clk_in, .backplane_level_ff,
        .segment_level_ff, .size_wide_ff, .panel_active_ff, .frame_start_ff);
    lcd_glass u_glass (.ref_clk, .bp_level(backplane_level_ff),
        .seg_level(segment_level_ff), .lit_ff);

    // Clocks
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        rtc_clk_in = 1'b0;
        forever begin
            repeat (4) @(negedge ref_clk);
            rtc_clk_in = ~rtc_clk_in;
        end
    end

    // Compare and verdict
    task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Register access, request held across the taking edge
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] v);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        rd_q.push_back(v);
        @(negedge ref_clk);
        sfr_rd = 1'b0;
    endtask
    function automatic logic [7:0] dadr(int r);
        return 8'(r < 6 ? 8'h89 + r : r < 13 ? 8'h8b + r : 8'h8c + r);
    endfunction

    // Read data monitor
    always @(posedge ref_clk) rd_seen <= sfr_rd;
    always @(negedge ref_clk) begin
        if (rd_seen === 1'b1) begin
            check("read data", sfr_rdata_ff, rd_q.pop_front());
        end
    end

    // Panel monitor, checks at a frame boundary, sampled mid-cycle
    always @(negedge ref_clk) begin
        cyc++;
        if (frame_start_ff === 1'b1) begin
            fcnt++;
            if (g_q.size() > 0 && fcnt >= g_q[0].at) begin
                check("segments", lit_ff & g_q[0].msk, g_q[0].exp);
                check("frame length", cyc - last_fs, g_q[0].per);
                void'(g_q.pop_front());
            end
            last_fs = cyc;
        end
    end

    // One panel setup in the documented order, then a glass check
    task automatic run_case(int m, int bi, int cd, bit blank);
        glass_t     e;
        logic [3:0] nib;
        wr(`PANEL_CONTROL_ADDR,
           8'({cd[1:0], blank, 1'b1, m[1:0], bi[0]}));
        wr(`PANEL_MISC_ADDR, 8'h50);
        // Supply comparator lies outside this block
        wr(`REFRESH_DIV_HIGH_ADDR, 8'h00);
        wr(`REFRESH_DIV_LOW_ADDR, 8'(bi));
        e.exp = '0;
        e.msk = '0;
        for (int r = 0; r < 16; r++) begin
            d[r] = 8'($urandom);
            wr(dadr(r), d[r]);
        end
        for (int p = 0; p < 32; p++) begin
            nib = d[p/2][4*(p%2)+:4];
            for (int b = 0; b <= m; b++) begin
                e.msk[4*p+b] = 1'b1;
                e.exp[4*p+b] = nib[b] & !blank;
            end
        end
        wr(`PANEL_MISC_ADDR, 8'h51);
        check("size select", size_wide_ff, 1'b1);
        e.at = fcnt + 3;
        e.per = (m + 1) * 2 * (bi + 1) * (1 << cd) * 8;
        g_q.push_back(e);
        for (int i = 0; i < 5000 && g_q.size() > 0; i++) @(negedge ref_clk);
        // A frame that never came counts as a mismatch
        if (g_q.size() > 0) begin
            check("frame timeout", 128'(g_q.size()), '0);
            g_q.delete();
        end
    endtask

    // Main sequence
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        rst_n = 1'b0;
        fail_count = 0;
        check_count = 0;
        cyc = 0;
        fcnt = 0;
        last_fs = 0;
        void'($urandom(65));
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1'b1;
        for (int r = 0; r < 16; r++) rd(dadr(r), 8'h00);
        rd(`PANEL_CONTROL_ADDR, 8'h00);
        rd(`REFRESH_DIV_LOW_ADDR, 8'h10);
        rd(`REFRESH_DIV_HIGH_ADDR, 8'h00);
        wr(8'h90, 8'h5a);
        rd(8'h90, 8'h00);
        for (int r = 0; r < 16; r++) begin
            d[r] = 8'($urandom);
            wr(dadr(r), d[r]);
            rd(dadr(r), d[r]);
        end
        d[0] = 8'($urandom) | 8'h80;
        wr(`PANEL_CONTROL_ADDR, d[0]);
        rd(`PANEL_CONTROL_ADDR, d[0] & 8'h7f);
        wr(`PANEL_MISC_ADDR, 8'h50);
        rd(`PANEL_MISC_ADDR, 8'h50);
        for (int m = 0; m < 4; m++) begin
            for (int bi = 0; bi < 2; bi++) run_case(m, bi, m % 3, 1'b0);
        end
        run_case(3, 0, 0, 1'b1);
        report_and_stop();
    end

    // Watchdog
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule // tb
